// >>> tpo_pkg.sv
// constants and types for the trace port output configuration block
package tpo_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_SUPP_WIDTH = 12'h000;
    localparam logic [11:0] ADDR_CUR_WIDTH = 12'h004;
    localparam logic [11:0] ADDR_PRESCALE = 12'h010;
    localparam logic [11:0] ADDR_PROTOCOL = 12'h0f0;
    localparam logic [11:0] ADDR_TYPE = 12'hfc8;
    // type register field positions
    localparam int TYPE_FIFOSZ_LSB = 6;
    localparam int TYPE_PT_ABSENT_BIT = 9;
    localparam int TYPE_MANC_BIT = 10;
    localparam int TYPE_NRZ_BIT = 11;
    // protocol field encodings
    localparam logic [1:0] PROTO_PARALLEL = 2'h0;
    localparam logic [1:0] PROTO_MANCHESTER = 2'h1;
    localparam logic [1:0] PROTO_NRZ = 2'h2;
    localparam logic [1:0] PROTO_RESERVED = 2'h3;
    // values after reset
    localparam logic [1:0] PROTO_RESET = 2'h0;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    // field widths and counts
    localparam int PRESCALE_FIELD_W = 16;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    // serial transmitter states
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } tpo_tx_e;
endpackage

// >>> tpo_trace_port.sv
// trace port output stage: configuration registers, baud prescaler and output encoders
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// How it works
// - supported widths read-only, bit N set means parallel width N+1 exists.
// - with the parallel port absent both width registers read zero and ignore writes.
// - current width resets to the one-hot code of the smallest supported width.
// - parallel output drives width N+1 when current width bit N is set.
// - a prescaler write reloads the baud counter at once.
// - with neither serial encoding present the prescaler reads zero and ignores writes.
// - the baud counter is loaded with the prescale value and counts down.
// - prescale bits above the implemented range read zero and ignore writes.
// - prescale sits in bits 15:0, so the NRZ bit rate is reference clock over value plus one, Manchester half that.
// - protocol field bits 1:0, 00 parallel, 01 Manchester, 11 reserved.
// - NRZ output is a UART frame whose start bit may be short, Manchester is the slower serial option.
module tpo_trace_port #(
    parameter logic [31:0] SUPPORTED_WIDTHS = 32'h0000008b,
    parameter bit PARALLEL_PRESENT = 1'b1,
    parameter bit MANCHESTER_PRESENT = 1'b1,
    parameter bit NRZ_PRESENT = 1'b1,
    parameter int PRESCALE_BITS = 16,
    parameter logic [2:0] FIFO_SIZE_LOG2 = 3'h3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // trace data stream in
    input wire logic [31:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // trace pins
    output logic [31:0] trace_par_data,
    output logic trace_par_strobe,
    output logic trace_serial_out
);
    // reset value of the current width: lowest supported bit only
    function automatic logic [31:0] lowest_bit(input logic [31:0] v);
        lowest_bit = v & (~v + 32'h00000001);
    endfunction

    // pin mask of width N+1 from a one-hot code with bit N set
    function automatic logic [31:0] width_mask(input logic [31:0] onehot);
        width_mask = (onehot == 32'h00000000) ? 32'h00000000 : (onehot | (onehot - 32'h00000001));
    endfunction

    // byte-lane merge of a write into the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                merge[8*i +: 8] = wr[8*i +: 8];
        end
    endfunction

    // line level of a bit: Manchester gives the bit then its inverse
    function automatic logic encode(input logic b, input logic half, input logic manc);
        encode = manc ? (b ^ half) : b;
    endfunction
    localparam logic SERIAL_PRESENT = MANCHESTER_PRESENT | NRZ_PRESENT;
    localparam logic [31:0] PRESC_MASK_W = (32'h1 << PRESCALE_BITS) - 32'h1;
    localparam logic [15:0] PRESC_MASK = PRESC_MASK_W[15:0];
    localparam logic [31:0] CUR_WIDTH_RESET = PARALLEL_PRESENT ? lowest_bit(SUPPORTED_WIDTHS) : 32'h0;
    localparam logic [31:0] TYPE_WORD = (32'(NRZ_PRESENT) << tpo_pkg::TYPE_NRZ_BIT)
        | (32'(MANCHESTER_PRESENT) << tpo_pkg::TYPE_MANC_BIT)
        | (32'(!PARALLEL_PRESENT) << tpo_pkg::TYPE_PT_ABSENT_BIT)
        | (32'(FIFO_SIZE_LOG2) << tpo_pkg::TYPE_FIFOSZ_LSB);

    //////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] cur_width;
    logic [15:0] prescale;
    logic [1:0] protocol;
    logic [31:0] next_cur_width;
    logic [15:0] next_prescale;
    logic [1:0] next_protocol;
    logic [31:0] next_dat;
    logic next_ack;
    logic presc_write;
    logic [31:0] wr_word;

    // bus decode: one request answered one cycle later, unmapped reads give zero
    always_comb
    begin
        next_cur_width = cur_width;
        next_prescale = prescale;
        next_protocol = protocol;
        next_dat = wb_dat_o;
        next_ack = 1'b0;
        presc_write = 1'b0;
        wr_word = 32'h00000000;
        if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            next_ack = 1'b1;
            next_dat = 32'h00000000;
            if (wb_adr_i == tpo_pkg::ADDR_SUPP_WIDTH)
            begin
                if (!wb_we_i && PARALLEL_PRESENT)
                    next_dat = SUPPORTED_WIDTHS;
            end
            else if (wb_adr_i == tpo_pkg::ADDR_CUR_WIDTH)
            begin
                wr_word = merge(cur_width, wb_dat_i, wb_sel_i);
                if (wb_we_i && PARALLEL_PRESENT)
                    next_cur_width = wr_word;
                else if (!wb_we_i)
                    next_dat = cur_width;
            end
            else if (wb_adr_i == tpo_pkg::ADDR_PRESCALE)
            begin
                wr_word = merge({16'h0000, prescale}, wb_dat_i, wb_sel_i);
                // value in bits 15:0, upper reserved
                if (wb_we_i && SERIAL_PRESENT)
                begin
                    next_prescale = wr_word[15:0] & PRESC_MASK;
                    presc_write = 1'b1;
                end
                else if (!wb_we_i)
                    next_dat = {16'h0000, prescale};
            end
            else if (wb_adr_i == tpo_pkg::ADDR_PROTOCOL)
            begin
                wr_word = merge({30'h0, protocol}, wb_dat_i, wb_sel_i);
                if (wb_we_i)
                    next_protocol = wr_word[1:0];
                else
                    next_dat = {30'h0, protocol};
            end
            else if (wb_adr_i == tpo_pkg::ADDR_TYPE)
            begin
                if (!wb_we_i)
                    next_dat = TYPE_WORD;
            end
        end
    end

    // register and bus flops
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur_width <= CUR_WIDTH_RESET;
            prescale <= tpo_pkg::PRESCALE_RESET;
            protocol <= tpo_pkg::PROTO_RESET;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            cur_width <= next_cur_width;
            prescale <= next_prescale;
            protocol <= next_protocol;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // baud prescaler
    logic [15:0] baud_cnt;
    logic baud_tick;
    logic [15:0] next_baud_cnt;
    logic next_baud_tick;

    // load and count down; tick every prescale plus one cycles
    always_comb
    begin
        next_baud_cnt = baud_cnt;
        next_baud_tick = 1'b0;
        // reload at once on write, no stale period
        if (presc_write)
            next_baud_cnt = next_prescale;
        else if (baud_cnt == 16'h0000)
        begin
            next_baud_cnt = prescale;
            next_baud_tick = 1'b1;
        end
        else
            next_baud_cnt = baud_cnt - 16'h0001;
    end

    // prescaler flops
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            baud_cnt <= tpo_pkg::PRESCALE_RESET;
            baud_tick <= 1'b0;
        end
        else
        begin
            baud_cnt <= next_baud_cnt;
            baud_tick <= next_baud_tick;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // output encoders
    tpo_pkg::tpo_tx_e tx_state;
    tpo_pkg::tpo_tx_e next_tx_state;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [2:0] tx_bit_cnt;
    logic [2:0] next_tx_bit_cnt;
    logic tx_half;
    logic next_tx_half;
    logic next_serial;
    logic next_in_ready;
    logic [31:0] next_par_data;
    logic next_par_strobe;
    logic manc;
    logic nrz;
    logic cur_bit;

    // one byte per serial frame; parallel takes one word per cycle
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_bit_cnt = tx_bit_cnt;
        next_tx_half = tx_half;
        next_serial = trace_serial_out;
        next_par_data = trace_par_data;
        next_par_strobe = 1'b0;
        manc = (protocol == tpo_pkg::PROTO_MANCHESTER);
        nrz = (protocol == tpo_pkg::PROTO_NRZ);
        cur_bit = (tx_state == tpo_pkg::TX_DATA) ? tx_shift[0] : manc;
        case (tx_state)
            tpo_pkg::TX_IDLE:
            begin
                next_serial = nrz;
                if (in_valid && in_ready && protocol == tpo_pkg::PROTO_PARALLEL)
                begin
                    // drive only the low N+1 pins
                    next_par_data = in_data & width_mask(cur_width);
                    next_par_strobe = 1'b1;
                end
                else if (in_valid && in_ready && (manc || nrz))
                begin
                    next_tx_shift = in_data[7:0];
                    next_tx_bit_cnt = 3'h0;
                    next_tx_half = 1'b0;
                    next_tx_state = tpo_pkg::TX_START;
                    next_serial = encode(manc, 1'b0, manc);
                end
            end
            default:
            begin
                // Manchester splits each bit into two ticks, NRZ one
                if (baud_tick && manc && !tx_half)
                begin
                    next_tx_half = 1'b1;
                    next_serial = (tx_state == tpo_pkg::TX_STOP) ? 1'b0 : encode(cur_bit, 1'b1, 1'b1);
                end
                else if (baud_tick)
                begin
                    next_tx_half = 1'b0;
                    if (tx_state == tpo_pkg::TX_START)
                    begin
                        next_tx_state = tpo_pkg::TX_DATA;
                        next_serial = encode(tx_shift[0], 1'b0, manc);
                    end
                    else if (tx_state == tpo_pkg::TX_DATA && tx_bit_cnt != tpo_pkg::LAST_DATA_BIT)
                    begin
                        next_tx_shift = {1'b0, tx_shift[7:1]};
                        next_tx_bit_cnt = tx_bit_cnt + 3'h1;
                        next_serial = encode(tx_shift[1], 1'b0, manc);
                    end
                    else if (tx_state == tpo_pkg::TX_DATA)
                    begin
                        // UART stop level high, Manchester line rests low
                        next_tx_state = tpo_pkg::TX_STOP;
                        next_serial = nrz;
                    end
                    else
                    begin
                        next_tx_state = tpo_pkg::TX_IDLE;
                        next_serial = nrz;
                    end
                end
            end
        endcase
        // reserved protocol stalls the stream rather than dropping data
        if (next_protocol == tpo_pkg::PROTO_PARALLEL)
            next_in_ready = 1'b1;
        else
            next_in_ready = (next_protocol != tpo_pkg::PROTO_RESERVED) && (next_tx_state == tpo_pkg::TX_IDLE);
    end

    // encoder flops
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_state <= tpo_pkg::TX_IDLE;
            tx_shift <= 8'h00;
            tx_bit_cnt <= 3'h0;
            tx_half <= 1'b0;
            trace_serial_out <= 1'b0;
            in_ready <= 1'b0;
            trace_par_data <= 32'h00000000;
            trace_par_strobe <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_bit_cnt <= next_tx_bit_cnt;
            tx_half <= next_tx_half;
            trace_serial_out <= next_serial;
            in_ready <= next_in_ready;
            trace_par_data <= next_par_data;
            trace_par_strobe <= next_par_strobe;
        end
    end
endmodule

// >>> tpo_trace_port_properties.sv
// bus and trace pin timing checks for the trace port output stage
`timescale 1ns/1ns
module tpo_trace_port_properties #(
    parameter logic [31:0] SUPPORTED_WIDTHS = 32'h0000008b
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // trace stream and pins
    input wire logic [31:0] in_data,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [31:0] trace_par_data,
    input wire logic trace_par_strobe,
    input wire logic trace_serial_out
);
    logic wr, rd, take;
    logic [1:0] proto, next_proto;
    logic [31:0] wsel, next_wsel;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // shadows follow full-word writes only, the bench never uses partial lanes
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign take = in_valid && in_ready;
    assign next_proto = (wr && wb_adr_i == tpo_pkg::ADDR_PROTOCOL) ? wb_dat_i[1:0] : proto;
    assign next_wsel = (wr && wb_adr_i == tpo_pkg::ADDR_CUR_WIDTH) ? wb_dat_i : wsel;
    // shadow registers, reset like the design's own
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            proto <= tpo_pkg::PROTO_RESET;
            wsel <= SUPPORTED_WIDTHS & (~SUPPORTED_WIDTHS + 32'h1);
        end
        else
        begin
            proto <= next_proto;
            wsel <= next_wsel;
        end
    end
    ////////////////////////////////////////
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_supp_value: assert property (rd && wb_adr_i == tpo_pkg::ADDR_SUPP_WIDTH |=> wb_dat_o == SUPPORTED_WIDTHS)
        else $error("supported widths wrong");
    chk_width_readback: assert property (rd && wb_adr_i == tpo_pkg::ADDR_CUR_WIDTH |=> wb_dat_o == $past(wsel))
        else $error("current width wrong");
    chk_prescale_upper: assert property (rd && wb_adr_i == tpo_pkg::ADDR_PRESCALE |=> wb_dat_o[31:16] == 16'h0000)
        else $error("prescale upper bits set");
    chk_proto_readback: assert property (rd && wb_adr_i == tpo_pkg::ADDR_PROTOCOL |=> wb_dat_o == {30'h0, $past(proto)})
        else $error("protocol readback wrong");
    chk_par_masked: assert property (proto == tpo_pkg::PROTO_PARALLEL && take |=> trace_par_strobe && trace_par_data == ($past(in_data) & (wsel | (wsel - 32'h1))))
        else $error("parallel word wrong");
    chk_reserved_stall: assert property (proto == tpo_pkg::PROTO_RESERVED && $past(proto) == tpo_pkg::PROTO_RESERVED |-> !in_ready)
        else $error("ready in reserved mode");
    chk_nrz_start: assert property (proto == tpo_pkg::PROTO_NRZ && take |=> !trace_serial_out && !in_ready)
        else $error("nrz start missing");
    chk_manc_start: assert property (proto == tpo_pkg::PROTO_MANCHESTER && take |=> trace_serial_out && !in_ready)
        else $error("manchester start missing");
endmodule
bind tpo_trace_port tpo_trace_port_properties #(.SUPPORTED_WIDTHS(SUPPORTED_WIDTHS)) i_tpo_trace_port_properties (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .trace_par_data(trace_par_data),
    .trace_par_strobe(trace_par_strobe), .trace_serial_out(trace_serial_out));

// >>> tpo_capture_model.sv
// external trace capture device: parallel latch and serial receiver
`timescale 1ns/1ns
module tpo_capture_model (
    // trace pins
    input wire logic ref_clk,
    input wire logic serial_in,
    input wire logic par_strobe,
    input wire logic [31:0] par_data,
    // receiver setup
    input wire logic [1:0] mode,
    input wire logic [16:0] tick,
    // captured results
    output logic [31:0] last_word = 32'h0,
    output logic [7:0] last_byte = 8'h00,
    output logic [7:0] byte_count = 8'h00,
    output logic frame_bad = 1'b0
);
    logic prev = 1'b0;
    // serial bits, lsb first, sampled mid-bit for NRZ, mid first half for Manchester
    task automatic take_byte(input int lead, input int step);
        begin
            repeat (lead) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                last_byte[i] = serial_in;
                repeat (step) @(posedge ref_clk);
            end
        end
    endtask
    // parallel words latched on the strobe
    always @(posedge ref_clk)
    begin
        if (par_strobe)
            last_word <= par_data;
    end
    ////////////////////////////////////////
    // serial framing, bit time in ticks
    always
    begin
        @(posedge ref_clk);
        if (mode != tpo_pkg::PROTO_PARALLEL && prev && !serial_in)
        begin
            // start may be short, so nrz needs data bit 0 high to find the tick
            if (mode == tpo_pkg::PROTO_NRZ)
            begin
                while (!serial_in) @(posedge ref_clk);
                take_byte(tick / 2, tick);
            end
            else
                take_byte(tick + tick / 2, 2 * tick);
            if (serial_in !== (mode == tpo_pkg::PROTO_NRZ))
                frame_bad = 1'b1;
            byte_count = byte_count + 8'h01;
        end
        prev = serial_in;
    end
endmodule

// >>> tpo_trace_port_bench.sv
// self-checking bench for the trace port output stage
`timescale 1ns/1ns
module tpo_trace_port_bench;
    typedef struct packed {logic [11:0] adr; logic we; logic [31:0] wdat; logic [31:0] exp;} tpo_row_s;
    localparam logic [31:0] TYPE_EXP = 32'h00000cc0;
    logic ref_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, in_data = 32'h0, trace_par_data, last_word, rd;
    logic wb_ack_o, in_valid = 1'b0, in_ready, trace_par_strobe, trace_serial_out, frame_bad;
    logic [1:0] mode = 2'h0;
    logic [16:0] tick = 17'h00001;
    logic [7:0] last_byte, byte_count;
    logic [31:0] widths [4] = '{32'h1, 32'h2, 32'h8, 32'h80};
    int cycles = 0, num_errors = 0, checks_done = 0;
    tpo_row_s rows [10] = '{
        '{tpo_pkg::ADDR_CUR_WIDTH, 1'b0, 32'h0, 32'h00000001},
        '{tpo_pkg::ADDR_SUPP_WIDTH, 1'b1, 32'hffffffff, 32'h0000008b},
        '{tpo_pkg::ADDR_CUR_WIDTH, 1'b1, 32'h00000008, 32'h00000008},
        '{tpo_pkg::ADDR_PRESCALE, 1'b0, 32'h0, 32'h00000000},
        '{tpo_pkg::ADDR_PRESCALE, 1'b1, 32'hffffffff, 32'h0000ffff},
        '{tpo_pkg::ADDR_PRESCALE, 1'b1, 32'h00000003, 32'h00000003},
        '{tpo_pkg::ADDR_TYPE, 1'b1, 32'hffffffff, TYPE_EXP},
        '{12'h008, 1'b1, 32'h12345678, 32'h00000000},
        '{tpo_pkg::ADDR_PROTOCOL, 1'b1, 32'h00000001, 32'h00000001},
        '{tpo_pkg::ADDR_PROTOCOL, 1'b1, 32'hffffffff, 32'h00000003}};
    tpo_trace_port i_tpo_trace_port (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .trace_par_data(trace_par_data), .trace_par_strobe(trace_par_strobe), .trace_serial_out(trace_serial_out));
    tpo_capture_model i_tpo_capture_model (.ref_clk(ref_clk), .serial_in(trace_serial_out),
        .par_strobe(trace_par_strobe), .par_data(trace_par_data), .mode(mode), .tick(tick),
        .last_word(last_word), .last_byte(last_byte), .byte_count(byte_count), .frame_bad(frame_bad));
    ////////////////////////////////////////
    task automatic compare(input logic [31:0] seen, input logic [31:0] want);
        begin
            checks_done++;
            if (seen !== want)
            begin
                num_errors++;
                $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask
    task automatic report_and_stop;
        begin
            if (num_errors == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic [11:0] adr, input logic we, input logic [31:0] wdat, output logic [31:0] rdat);
        begin
            @(posedge ref_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= adr;
            wb_dat_i <= wdat;
            do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
            rdat = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    task automatic send(input logic [31:0] d);
        begin
            @(posedge ref_clk);
            in_data <= d;
            in_valid <= 1'b1;
            do @(posedge ref_clk); while (in_ready !== 1'b1);
            in_valid <= 1'b0;
        end
    endtask
    // protocol changed only between frames, supported ones only
    task automatic set_proto(input logic [1:0] p);
        begin
            // receiver parked while the idle level moves, else a falling idle level looks like a start bit
            mode <= tpo_pkg::PROTO_PARALLEL;
            wb(tpo_pkg::ADDR_PROTOCOL, 1'b1, {30'h0, p}, rd);
            repeat (2) @(posedge ref_clk);
            mode <= p;
        end
    endtask
    task automatic serial_byte(input logic [31:0] d, input logic [7:0] n);
        begin
            send(d);
            while (byte_count !== n) @(posedge ref_clk);
            compare({24'h0, last_byte}, d & 32'hff);
        end
    endtask
    always #10 ref_clk = ~ref_clk;
    // hang guard, the whole run needs far fewer cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].we)
                wb(rows[i].adr, 1'b1, rows[i].wdat, rd);
            wb(rows[i].adr, 1'b0, 32'h0, rd);
            compare(rd, rows[i].exp);
        end
        // reserved protocol holds the stream off
        in_valid <= 1'b1;
        repeat (4) @(posedge ref_clk);
        compare({31'h0, in_ready}, 32'h0);
        in_valid <= 1'b0;
        set_proto(tpo_pkg::PROTO_PARALLEL);
        foreach (widths[i])
        begin
            wb(tpo_pkg::ADDR_CUR_WIDTH, 1'b1, widths[i], rd);
            send(32'hdeadbeef);
            repeat (2) @(posedge ref_clk);
            compare(last_word, 32'hdeadbeef & (widths[i] | (widths[i] - 32'h1)));
        end
        tick <= 17'h00004;
        set_proto(tpo_pkg::PROTO_NRZ);
        serial_byte(32'h000000a5, 8'h01);
        // new prescale reloads the baud counter at once, the next frame runs at it
        wb(tpo_pkg::ADDR_PRESCALE, 1'b1, 32'h00000001, rd);
        tick <= 17'h00002;
        serial_byte(32'h5a5a5a37, 8'h02);
        set_proto(tpo_pkg::PROTO_MANCHESTER);
        serial_byte(32'h0000005a, 8'h03);
        compare({31'h0, frame_bad}, 32'h0);
        // second reset mid-run restores the reset values
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        wb(tpo_pkg::ADDR_CUR_WIDTH, 1'b0, 32'h0, rd);
        compare(rd, 32'h00000001);
        wb(tpo_pkg::ADDR_PRESCALE, 1'b0, 32'h0, rd);
        compare(rd, 32'h00000000);
        report_and_stop();
    end
endmodule
